// ===== design/fms_fault_manager_sequencer.sv
// Fault supervision and start-up sequencing for an off-line power controller
`timescale 1ns/100ps

module fms_fault_manager_sequencer #(
	parameter logic [fms_pkg::CNT_W-1:0] RECOVERY_CYC     = fms_pkg::CNT_W'(fms_pkg::RECOVERY_CYC),
	parameter logic [fms_pkg::CNT_W-1:0] BROWNOUT_CYC     = fms_pkg::CNT_W'(fms_pkg::BROWNOUT_CYC),
	parameter logic [fms_pkg::CNT_W-1:0] LINE_REMOVAL_CYC =
		fms_pkg::CNT_W'(fms_pkg::LINE_REMOVAL_CYC),
	parameter logic [fms_pkg::CNT_W-1:0] DISCH_PHASE_CYC  =
		fms_pkg::CNT_W'(fms_pkg::DISCH_PHASE_CYC)
) (
	input  wire logic                          clk_sys_in,
	input  wire logic                          reset_n_in,
	input  wire fms_pkg::fms_cmp_type          cmp_in,
	input  wire logic                          variant_auto_in,
	input  wire logic                          soft_start_active_in,
	input  wire logic                          overload_fault_in,
	input  wire logic                          line_sample_valid_in,
	input  wire logic [fms_pkg::SAMPLE_W-1:0]  line_sample_in,
	output logic                               gate_drive_enable_out,
	output logic                               startup_source_on_out,
	output logic                               discharge_on_out,
	output logic                               fault_pin_pullup_on_out,
	output fms_pkg::fms_state_type             state_out
);

	localparam logic [fms_pkg::CNT_W-1:0] BLANK_CYC = fms_pkg::CNT_W'(fms_pkg::BLANKING_CYC);

	// Two-flop synchronisers for every analog comparator and the strap
	fms_pkg::fms_cmp_type cmp_meta_reg;
	fms_pkg::fms_cmp_type cmp_reg;
	logic                 strap_meta_reg;
	logic                 strap_sync_reg;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cmp_meta_reg   <= '0;
			cmp_reg        <= '0;
			strap_meta_reg <= fms_pkg::STRAP_LATCH;
			strap_sync_reg <= fms_pkg::STRAP_LATCH;
		end else begin
			cmp_meta_reg   <= cmp_in;
			cmp_reg        <= cmp_meta_reg;
			strap_meta_reg <= variant_auto_in;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// Strap taken once the sync chain holds a post-reset value, frozen afterwards
	// An earlier capture would only see the chain's own reset default
	logic       variant_auto_reg;
	logic       strap_taken_reg;
	logic [1:0] strap_fill_reg;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			variant_auto_reg <= fms_pkg::STRAP_LATCH;
			strap_taken_reg  <= 1'h0;
			strap_fill_reg   <= 2'h0;
		end else begin
			strap_fill_reg <= {strap_fill_reg[0], 1'h1};
			if (strap_fill_reg[1] && !strap_taken_reg) begin
				variant_auto_reg <= strap_sync_reg;
				strap_taken_reg  <= 1'h1;
			end
		end
	end

	fms_pkg::fms_state_type state_reg;
	fms_pkg::fms_state_type state_next;

	// State groups shared by sequencing, supply control and outputs
	function automatic logic state_discharging(input fms_pkg::fms_state_type s);
		state_discharging = (s == fms_pkg::ST_DISCH_PULL) |
			(s == fms_pkg::ST_DISCH_PHASE) | (s == fms_pkg::ST_DISCH_CHECK);
	endfunction : state_discharging

	function automatic logic state_holds_supply(input fms_pkg::fms_state_type s);
		state_holds_supply = (s == fms_pkg::ST_OFF) | (s == fms_pkg::ST_NONLATCH) |
			(s == fms_pkg::ST_LATCHED) | (s == fms_pkg::ST_AUTOREC);
	endfunction : state_holds_supply

	function automatic logic state_regulates(input fms_pkg::fms_state_type s);
		state_regulates = (s == fms_pkg::ST_DISCH_PHASE) | (s == fms_pkg::ST_DISCH_CHECK);
	endfunction : state_regulates

	function automatic logic state_sinks_line(input fms_pkg::fms_state_type s);
		state_sinks_line = (s == fms_pkg::ST_DISCH_PULL) | (s == fms_pkg::ST_DISCH_PHASE);
	endfunction : state_sinks_line

	// Fault input blanking filters
	logic [fms_pkg::CNT_W-1:0] upper_cnt_reg;
	logic [fms_pkg::CNT_W-1:0] lower_cnt_reg;
	wire  upper_fault   = (upper_cnt_reg == BLANK_CYC);
	wire  lower_armed   = cmp_reg.fault_input_below_lower & ~soft_start_active_in;
	wire  lower_fault   = (lower_cnt_reg == BLANK_CYC);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			upper_cnt_reg <= fms_pkg::CNT_ZERO;
			lower_cnt_reg <= fms_pkg::CNT_ZERO;
		end else begin
			// Any gap restarts the count; saturation keeps the fault standing
			if (!cmp_reg.fault_input_above_upper)
				upper_cnt_reg <= fms_pkg::CNT_ZERO;
			else if (!upper_fault)
				upper_cnt_reg <= upper_cnt_reg + fms_pkg::CNT_ONE;
			if (!lower_armed)
				lower_cnt_reg <= fms_pkg::CNT_ZERO;
			else if (!lower_fault)
				lower_cnt_reg <= lower_cnt_reg + fms_pkg::CNT_ONE;
		end
	end

	// Brownout timer
	// Any return above stop restarts the count, so short dropouts pass
	logic [fms_pkg::CNT_W-1:0] bo_cnt_reg;
	logic                      brownout_reg;
	wire  bo_expire = cmp_reg.line_below_bo_stop & (bo_cnt_reg == BROWNOUT_CYC);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bo_cnt_reg   <= fms_pkg::CNT_ZERO;
			brownout_reg <= 1'h0;
		end else begin
			bo_cnt_reg <= !cmp_reg.line_below_bo_stop ? fms_pkg::CNT_ZERO :
				bo_expire ? bo_cnt_reg : bo_cnt_reg + fms_pkg::CNT_ONE;
			if (bo_expire)
				brownout_reg <= 1'h1;
			else if (cmp_reg.line_above_bo_start)
				brownout_reg <= 1'h0;
		end
	end

	// Line slope monitor; a rising sample proves the line is present
	logic [fms_pkg::SAMPLE_W-1:0] last_sample_reg;
	logic [fms_pkg::CNT_W-1:0]    removal_cnt_reg;
	wire  slope_positive = line_sample_valid_in & (line_sample_in > last_sample_reg);
	wire  line_removal   = (removal_cnt_reg == LINE_REMOVAL_CYC) & ~slope_positive;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_sample_reg <= '0;
			removal_cnt_reg <= fms_pkg::CNT_ZERO;
		end else begin
			if (line_sample_valid_in)
				last_sample_reg <= line_sample_in;
			// Restart after expiry so a dead line keeps re-arming discharge
			if (slope_positive || line_removal)
				removal_cnt_reg <= fms_pkg::CNT_ZERO;
			else
				removal_cnt_reg <= removal_cnt_reg + fms_pkg::CNT_ONE;
		end
	end

	// Fault classes
	wire  otp_latch     = lower_fault & ~variant_auto_reg;
	wire  otp_auto      = lower_fault & variant_auto_reg;
	wire  latch_now     = cmp_reg.abnormal_overcurrent_fault | cmp_reg.vcc_ovp |
		cmp_reg.external_latch | upper_fault | otp_latch;
	wire  nonlatch_now  = brownout_reg | cmp_reg.thermal_shutdown;
	// Overload timing sits outside; only its expiry arrives here
	wire  auto_now      = overload_fault_in | otp_auto;
	wire  in_discharge  = state_discharging(state_reg);
	// Discharge is entered only through line removal, so one term covers both clears
	wire  latch_clear   = cmp_reg.vcc_below_reset | line_removal;

	logic latched_reg;
	logic otp_hold_reg;

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			latched_reg <= 1'h0;
		end else if (latch_now) begin
			latched_reg <= 1'h1;
		end else if (latch_clear) begin
			latched_reg <= 1'h0;
		end
	end

	// Auto variant overtemperature holds until the pin rises past release
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			otp_hold_reg <= 1'h0;
		end else if (otp_auto) begin
			otp_hold_reg <= 1'h1;
		end else if (cmp_reg.fault_input_above_release) begin
			otp_hold_reg <= 1'h0;
		end
	end

	// Shared timer: recovery in auto-recovery, phase limit during discharge
	// The two uses never overlap, so one counter serves both
	logic [fms_pkg::CNT_W-1:0] tmr_reg;
	logic [fms_pkg::CNT_W-1:0] tmr_next;
	wire  tmr_done = (tmr_reg == fms_pkg::CNT_ZERO);

	wire  line_ok     = cmp_reg.line_above_bo_start;
	wire  start_ok    = cmp_reg.vcc_above_on & line_ok;

	always_comb begin
		state_next = state_reg;
		tmr_next   = tmr_done ? tmr_reg : tmr_reg - fms_pkg::CNT_ONE;
		if (line_removal) begin
			state_next = fms_pkg::ST_DISCH_PULL;
		end else if (latch_now || latched_reg) begin
			if (!in_discharge)
				state_next = fms_pkg::ST_LATCHED;
		end else begin
			unique case (state_reg)
				fms_pkg::ST_OFF, fms_pkg::ST_LATCHED: begin
					// Latched state leaves only once the flag clears
					if (nonlatch_now)
						state_next = fms_pkg::ST_NONLATCH;
					else if (start_ok)
						state_next = fms_pkg::ST_RUN;
					else
						state_next = fms_pkg::ST_OFF;
				end
				fms_pkg::ST_RUN: begin
					if (nonlatch_now) begin
						state_next = fms_pkg::ST_NONLATCH;
					end else if (auto_now) begin
						state_next = fms_pkg::ST_AUTOREC;
						tmr_next   = RECOVERY_CYC;
					end
				end
				fms_pkg::ST_NONLATCH: begin
					if (!nonlatch_now && start_ok)
						state_next = fms_pkg::ST_RUN;
				end
				fms_pkg::ST_AUTOREC: begin
					if (tmr_done && start_ok && !otp_hold_reg)
						state_next = fms_pkg::ST_RUN;
				end
				fms_pkg::ST_DISCH_PULL: begin
					if (!cmp_reg.vcc_above_on) begin
						state_next = fms_pkg::ST_DISCH_PHASE;
						tmr_next   = DISCH_PHASE_CYC;
					end
				end
				fms_pkg::ST_DISCH_PHASE: begin
					if (cmp_reg.line_below_discharge_end) begin
						state_next = fms_pkg::ST_OFF;
					end else if (tmr_done) begin
						state_next = fms_pkg::ST_DISCH_CHECK;
						tmr_next   = DISCH_PHASE_CYC;
					end
				end
				fms_pkg::ST_DISCH_CHECK: begin
					if (slope_positive || cmp_reg.line_below_discharge_end) begin
						state_next = fms_pkg::ST_OFF;
					end else if (tmr_done) begin
						state_next = fms_pkg::ST_DISCH_PHASE;
						tmr_next   = DISCH_PHASE_CYC;
					end
				end
			endcase
		end
	end

	// Startup source hysteresis and fault-pin pull-up
	logic src_on_reg;
	logic pullup_reg;
	wire  hold_between = state_holds_supply(state_reg);
	wire  regulate_x2  = state_regulates(state_reg);
	logic src_on_next;

	always_comb begin
		src_on_next = src_on_reg;
		if (hold_between) begin
			if (cmp_reg.vcc_below_off)
				src_on_next = 1'h1;
			else if (cmp_reg.vcc_above_on)
				src_on_next = 1'h0;
		end else if (regulate_x2) begin
			if (!cmp_reg.vcc_above_on)
				src_on_next = 1'h1;
			else if (cmp_reg.vcc_above_x2reg)
				src_on_next = 1'h0;
		end else begin
			src_on_next = 1'h0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg  <= fms_pkg::ST_OFF;
			tmr_reg    <= fms_pkg::CNT_ZERO;
			src_on_reg <= 1'h0;
		end else begin
			state_reg  <= state_next;
			tmr_reg    <= tmr_next;
			src_on_reg <= src_on_next;
		end
	end

	// Dropping with the supply makes every fresh power-up start with it off
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pullup_reg <= 1'h0;
		end else if (cmp_reg.vcc_below_reset) begin
			pullup_reg <= 1'h0;
		end else if (cmp_reg.vcc_above_on) begin
			pullup_reg <= 1'h1;
		end
	end

	// Drive stays combinationally gated so a fresh fault cuts it at once
	fms_pkg::fms_ctl_type ctl;
	assign ctl.gate_drive_enable   = (state_reg == fms_pkg::ST_RUN) & ~latch_now &
		~nonlatch_now & ~auto_now & ~line_removal;
	assign ctl.startup_source_on   = src_on_reg;
	assign ctl.discharge_on        = state_sinks_line(state_reg);
	assign ctl.fault_pin_pullup_on = pullup_reg;

	assign gate_drive_enable_out   = ctl.gate_drive_enable;
	assign startup_source_on_out   = ctl.startup_source_on;
	assign discharge_on_out        = ctl.discharge_on;
	assign fault_pin_pullup_on_out = ctl.fault_pin_pullup_on;
	assign state_out               = state_reg;

endmodule : fms_fault_manager_sequencer

// ===== design/fms_pkg.sv
// Constants and carrier types for the fault manager sequencer
package fms_pkg;

	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned CNT_W           = 24;
	localparam int unsigned SAMPLE_W        = 8;

	// Times as printed, in their own units
	localparam int unsigned RECOVERY_MS     = 1200;
	localparam int unsigned BROWNOUT_MS     = 54;
	localparam int unsigned LINE_REMOVAL_MS = 100;
	localparam int unsigned DISCH_PHASE_MS  = 32;
	localparam int unsigned BLANKING_US     = 30;

	// Longest times round down, blanking is a least time and rounds up
	localparam int unsigned RECOVERY_CYC     = RECOVERY_MS * (CLK_HZ / 1000);
	localparam int unsigned BROWNOUT_CYC     = BROWNOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned LINE_REMOVAL_CYC = LINE_REMOVAL_MS * (CLK_HZ / 1000);
	localparam int unsigned DISCH_PHASE_CYC  = DISCH_PHASE_MS * (CLK_HZ / 1000);
	localparam int unsigned BLANKING_CYC     = (BLANKING_US * CLK_HZ + 999_999) / 1_000_000;

	localparam logic [CNT_W-1:0] CNT_ZERO    = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE     = 24'h000001;
	localparam logic             STRAP_LATCH = 1'h0;

	// Comparator outputs arriving from the analog side
	typedef struct packed {
		logic vcc_above_on;
		logic vcc_below_off;
		logic vcc_below_reset;
		logic vcc_above_x2reg;
		logic vcc_ovp;
		logic line_above_bo_start;
		logic line_below_bo_stop;
		logic line_below_discharge_end;
		logic abnormal_overcurrent_fault;
		logic thermal_shutdown;
		logic fault_input_above_upper;
		logic fault_input_below_lower;
		logic fault_input_above_release;
		logic external_latch;
	} fms_cmp_type;

	typedef struct packed {
		logic gate_drive_enable;
		logic startup_source_on;
		logic discharge_on;
		logic fault_pin_pullup_on;
	} fms_ctl_type;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_NONLATCH,
		ST_LATCHED,
		ST_AUTOREC,
		ST_DISCH_PULL,
		ST_DISCH_PHASE,
		ST_DISCH_CHECK
	} fms_state_type;

endpackage : fms_pkg

// ===== dv/fms_fault_manager_sequencer_asserts.sv
// Port-level checker for the fault manager sequencer
`timescale 1ns/100ps
module fms_fault_manager_sequencer_asserts #(
	parameter logic [fms_pkg::CNT_W-1:0] DISCH_PHASE_CYC = 24'h000032
) (
	input wire logic                   clk_sys_in,
	input wire logic                   reset_n_in,
	input wire fms_pkg::fms_cmp_type   cmp_in,
	input wire logic                   gate_drive_enable_out,
	input wire logic                   startup_source_on_out,
	input wire logic                   discharge_on_out,
	input wire fms_pkg::fms_state_type state_out
);
	// Small slack for the state register hand-off at phase end
	localparam int PH_MAX = int'(DISCH_PHASE_CYC) + 2;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_latch_gate_off: assert property (
		$past(cmp_in.external_latch, 2) |-> !gate_drive_enable_out)
		else $error("gate on with latch input");
	a_gate_run_only: assert property (
		gate_drive_enable_out |-> state_out == fms_pkg::ST_RUN)
		else $error("gate on outside run");
	a_latch_exit: assert property (
		$past(state_out) == fms_pkg::ST_LATCHED && state_out != fms_pkg::ST_LATCHED |->
		state_out inside {fms_pkg::ST_OFF, fms_pkg::ST_DISCH_PULL})
		else $error("latch left without clear");
	a_latch_cause: assert property (
		$past(state_out) == fms_pkg::ST_RUN && state_out == fms_pkg::ST_LATCHED |->
		$past(cmp_in.external_latch, 3) || $past(cmp_in.vcc_ovp, 3) ||
		$past(cmp_in.abnormal_overcurrent_fault, 3) ||
		$past(cmp_in.fault_input_above_upper, 250) || $past(cmp_in.fault_input_below_lower, 250))
		else $error("latch without cause");
	a_source_rise: assert property (
		$rose(startup_source_on_out) |-> !$past(cmp_in.vcc_above_on, 3))
		else $error("source on above turn-on");
	a_disch_out: assert property (
		discharge_on_out == (state_out inside {fms_pkg::ST_DISCH_PULL, fms_pkg::ST_DISCH_PHASE}))
		else $error("discharge output mismatch");
	a_phase_bound: assert property (
		$rose(state_out == fms_pkg::ST_DISCH_PHASE) |-> ##[1:PH_MAX]
		state_out != fms_pkg::ST_DISCH_PHASE)
		else $error("discharge phase too long");
	a_brownout_wait: assert property (
		$past(state_out) == fms_pkg::ST_RUN && state_out == fms_pkg::ST_NONLATCH |->
		$past(cmp_in.line_below_bo_stop, 95) || $past(cmp_in.thermal_shutdown, 3))
		else $error("brownout declared early");
endmodule : fms_fault_manager_sequencer_asserts

bind fms_fault_manager_sequencer fms_fault_manager_sequencer_asserts #(
	.DISCH_PHASE_CYC(DISCH_PHASE_CYC)
) chk_u (
	.clk_sys_in           (clk_sys_in),
	.reset_n_in           (reset_n_in),
	.cmp_in               (cmp_in),
	.gate_drive_enable_out(gate_drive_enable_out),
	.startup_source_on_out(startup_source_on_out),
	.discharge_on_out     (discharge_on_out),
	.state_out            (state_out)
);

// ===== dv/fms_supply_model.sv
// Supply rail model answering the startup source with comparator levels
`timescale 1ns/100ps
module fms_supply_model (
	input  wire logic clk_sys_in,
	input  wire logic source_on_in,
	input  wire logic load_in,
	input  wire logic drain_in,
	output logic [3:0] vcc_flags_out
);
	int lvl = 0;
	// Running converter holds the rail; idle chip slowly sinks it
	always @(posedge clk_sys_in) begin
		if (drain_in) begin
			lvl <= (lvl > 1) ? lvl - 2 : 0;
		end else if (source_on_in) begin
			lvl <= (lvl < 100) ? lvl + 1 : 100;
		end else if (!load_in) begin
			lvl <= (lvl > 0) ? lvl - 1 : 0;
		end
	end
	// Above turn-on, below turn-off, below reset, above regulation
	assign vcc_flags_out = {lvl >= 70, lvl <= 40, lvl <= 10, lvl >= 90};
endmodule : fms_supply_model

// ===== dv/fms_fault_manager_sequencer_bench.sv
// Self-checking bench for the fault manager sequencer
`timescale 1ns/100ps
module fms_fault_manager_sequencer_bench;
	logic                   clk_sys_in = 1'b0;
	logic                   reset_n_in;
	fms_pkg::fms_cmp_type   drv;
	fms_pkg::fms_cmp_type   cmp_w;
	logic                   variant_auto_in;
	logic                   soft_start_active_in;
	logic                   overload_fault_in;
	logic                   line_sample_valid_in = 1'b0;
	logic [7:0]             line_sample_in = 8'h00;
	logic                   gate_drive_enable_out;
	logic                   startup_source_on_out;
	logic                   discharge_on_out;
	logic                   fault_pin_pullup_on_out;
	fms_pkg::fms_state_type state_out;
	logic [3:0]             vflags;
	logic [4:0]             smp_div = 5'h00;
	logic                   drain;
	logic                   alive;
	logic                   hit;
	int                     errors = 0;
	int                     num_checks = 0;
	int                     cyc = 0;

	assign cmp_w = {vflags, drv[9:0]};

	fms_fault_manager_sequencer #(
		.RECOVERY_CYC    (24'h0000c8),
		.BROWNOUT_CYC    (24'h000064),
		.LINE_REMOVAL_CYC(24'h000190),
		.DISCH_PHASE_CYC (24'h000032)
	) dut_u (
		.clk_sys_in             (clk_sys_in),
		.reset_n_in             (reset_n_in),
		.cmp_in                 (cmp_w),
		.variant_auto_in        (variant_auto_in),
		.soft_start_active_in   (soft_start_active_in),
		.overload_fault_in      (overload_fault_in),
		.line_sample_valid_in   (line_sample_valid_in),
		.line_sample_in         (line_sample_in),
		.gate_drive_enable_out  (gate_drive_enable_out),
		.startup_source_on_out  (startup_source_on_out),
		.discharge_on_out       (discharge_on_out),
		.fault_pin_pullup_on_out(fault_pin_pullup_on_out),
		.state_out              (state_out)
	);

	fms_supply_model model_u (
		.clk_sys_in   (clk_sys_in),
		.source_on_in (startup_source_on_out),
		.load_in      (gate_drive_enable_out),
		.drain_in     (drain),
		.vcc_flags_out(vflags)
	);

	initial begin
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// Rising samples keep the line-removal detector from firing
	always @(posedge clk_sys_in) begin
		smp_div <= smp_div + 5'h01;
		line_sample_valid_in <= alive && smp_div == 5'h00;
		if (alive && smp_div == 5'h00) begin
			line_sample_in <= line_sample_in + 8'h01;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			chk(1'b0, "timeout");
			complete_run();
		end
	end

	task automatic wait_st(input fms_pkg::fms_state_type s, input int n);
		hit = 1'b0;
		repeat (n) begin
			if (!hit) begin
				@(negedge clk_sys_in);
				hit = (state_out === s);
			end
		end
	endtask : wait_st

	task automatic drain_rail();
		@(posedge clk_sys_in);
		drain <= 1'b1;
		repeat (50) @(posedge clk_sys_in);
		drain <= 1'b0;
	endtask : drain_rail

	task automatic t_start();
		@(negedge clk_sys_in);
		chk(fault_pin_pullup_on_out === 1'b0, "pull-up early");
		wait_st(fms_pkg::ST_RUN, 300);
		chk(hit, "no start");
		chk(fault_pin_pullup_on_out === 1'b1, "pull-up off");
	endtask : t_start

	task automatic t_latch();
		@(posedge clk_sys_in);
		drv.external_latch <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk(gate_drive_enable_out === 1'b0, "gate after latch");
		wait_st(fms_pkg::ST_LATCHED, 4);
		chk(hit, "not latched");
		@(posedge clk_sys_in);
		drv.external_latch <= 1'b0;
		wait_st(fms_pkg::ST_RUN, 500);
		chk(!hit, "restart from latch");
		drain_rail();
		wait_st(fms_pkg::ST_RUN, 400);
		chk(hit, "no restart after reset");
	endtask : t_latch

	task automatic t_brownout();
		@(posedge clk_sys_in);
		drv.line_below_bo_stop <= 1'b1;
		drv.line_above_bo_start <= 1'b0;
		wait_st(fms_pkg::ST_NONLATCH, 60);
		chk(!hit, "early brownout");
		@(posedge clk_sys_in);
		drv.line_below_bo_stop <= 1'b0;
		@(posedge clk_sys_in);
		drv.line_below_bo_stop <= 1'b1;
		wait_st(fms_pkg::ST_NONLATCH, 85);
		chk(!hit, "timer not restarted");
		wait_st(fms_pkg::ST_NONLATCH, 40);
		chk(hit, "no brownout");
		@(posedge clk_sys_in);
		drv.line_below_bo_stop <= 1'b0;
		wait_st(fms_pkg::ST_RUN, 200);
		chk(!hit, "start below start level");
		@(posedge clk_sys_in);
		drv.line_above_bo_start <= 1'b1;
		wait_st(fms_pkg::ST_RUN, 200);
		chk(hit, "no restart");
		@(posedge clk_sys_in);
		drv.thermal_shutdown <= 1'b1;
		wait_st(fms_pkg::ST_NONLATCH, 5);
		chk(hit, "thermal ignored");
		wait_st(fms_pkg::ST_RUN, 200);
		chk(!hit, "start while hot");
		@(posedge clk_sys_in);
		drv.thermal_shutdown <= 1'b0;
		wait_st(fms_pkg::ST_RUN, 200);
		chk(hit, "no restart");
	endtask : t_brownout

	task automatic t_autorec();
		@(posedge clk_sys_in);
		overload_fault_in <= 1'b1;
		@(posedge clk_sys_in);
		overload_fault_in <= 1'b0;
		wait_st(fms_pkg::ST_AUTOREC, 3);
		chk(hit, "no recovery wait");
		wait_st(fms_pkg::ST_RUN, 150);
		chk(!hit, "early recovery");
		@(posedge clk_sys_in);
		drv.line_above_bo_start <= 1'b0;
		wait_st(fms_pkg::ST_RUN, 150);
		chk(!hit, "start on low line");
		@(posedge clk_sys_in);
		drv.line_above_bo_start <= 1'b1;
		wait_st(fms_pkg::ST_RUN, 200);
		chk(hit, "no recovery");
	endtask : t_autorec

	task automatic t_fault_pin();
		@(posedge clk_sys_in);
		soft_start_active_in <= 1'b1;
		drv.fault_input_below_lower <= 1'b1;
		wait_st(fms_pkg::ST_LATCHED, 400);
		chk(!hit, "lower seen in soft-start");
		@(posedge clk_sys_in);
		soft_start_active_in <= 1'b0;
		wait_st(fms_pkg::ST_LATCHED, 320);
		chk(hit, "lower not latched");
		@(posedge clk_sys_in);
		drv.fault_input_below_lower <= 1'b0;
		drain_rail();
		wait_st(fms_pkg::ST_RUN, 400);
		chk(hit, "no restart");
		@(posedge clk_sys_in);
		drv.fault_input_above_upper <= 1'b1;
		wait_st(fms_pkg::ST_LATCHED, 250);
		chk(!hit, "upper not blanked");
		@(posedge clk_sys_in);
		drv.fault_input_above_upper <= 1'b0;
		@(posedge clk_sys_in);
		drv.fault_input_above_upper <= 1'b1;
		wait_st(fms_pkg::ST_LATCHED, 330);
		chk(hit, "upper not latched");
		@(posedge clk_sys_in);
		drv.fault_input_above_upper <= 1'b0;
	endtask : t_fault_pin

	task automatic t_line();
		@(posedge clk_sys_in);
		alive <= 1'b0;
		wait_st(fms_pkg::ST_DISCH_PULL, 450);
		chk(hit, "no line removal");
		chk(discharge_on_out === 1'b1, "no discharge");
		wait_st(fms_pkg::ST_DISCH_PHASE, 100);
		chk(hit, "no phase");
		wait_st(fms_pkg::ST_DISCH_CHECK, 60);
		chk(hit, "phase unbounded");
		chk(discharge_on_out === 1'b0, "discharge in check");
		wait_st(fms_pkg::ST_DISCH_PHASE, 60);
		chk(hit, "no repeat");
		@(posedge clk_sys_in);
		drv.line_below_discharge_end <= 1'b1;
		wait_st(fms_pkg::ST_OFF, 60);
		chk(hit, "discharge not ended");
		@(posedge clk_sys_in);
		drv.line_below_discharge_end <= 1'b0;
		alive <= 1'b1;
		wait_st(fms_pkg::ST_RUN, 300);
		chk(hit, "no restart");
	endtask : t_line

	task automatic t_variant();
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		variant_auto_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		wait_st(fms_pkg::ST_RUN, 300);
		chk(hit, "no start after reset");
		@(posedge clk_sys_in);
		drv.fault_input_below_lower <= 1'b1;
		wait_st(fms_pkg::ST_AUTOREC, 320);
		chk(hit, "lower not recovering");
		@(posedge clk_sys_in);
		drv.fault_input_below_lower <= 1'b0;
		wait_st(fms_pkg::ST_RUN, 400);
		chk(!hit, "start before release");
		@(posedge clk_sys_in);
		drv.fault_input_above_release <= 1'b1;
		wait_st(fms_pkg::ST_RUN, 200);
		chk(hit, "no recovery after release");
		@(posedge clk_sys_in);
		drv.fault_input_above_release <= 1'b0;
	endtask : t_variant

	initial begin
		reset_n_in = 1'b0;
		drv = '0;
		drv.line_above_bo_start = 1'b1;
		variant_auto_in = 1'b0;
		soft_start_active_in = 1'b0;
		overload_fault_in = 1'b0;
		drain = 1'b0;
		alive = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		t_start();
		t_latch();
		t_brownout();
		t_autorec();
		t_fault_pin();
		t_line();
		t_variant();
		complete_run();
	end
endmodule : fms_fault_manager_sequencer_bench
